// >>> dv/sap_far_end.sv
`timescale 1ns/100ps
`include "sap_params.svh"
// ----------------------------------------
// far-end audio master, i2s framing
// ----------------------------------------
module sap_far_end
	import sap_pkg::*;
#(
	parameter int HALF_NS = 80
) (
	// control
	input  wire logic             run_i,
	input  wire sap_frame_t       left_i,
	input  wire sap_frame_t       right_i,
	// link pins
	output logic                  bit_clock_o,
	output logic                  frame_clock_o,
	output logic [`SAP_LANES-1:0] data_o
);
	int n;
	int p;

	// clock stands still between frames, stops only at a frame end
	initial begin
		bit_clock_o = 1'b1;
		frame_clock_o = 1'b1;
		data_o = '0;
		n = 0;
		forever begin
			if (!run_i && n == 0) begin
				// released lines: each data bit inverted from its last value
				data_o = ~data_o;
				wait (run_i);
				#13;
			end
			#HALF_NS;
			bit_clock_o = 1'b0;
			frame_clock_o = n >= 32;
			p = (n + 63) % 64;
			for (int l = 0; l < `SAP_LANES; l++) begin
				data_o[l] = p < 32 ? left_i.lane_data[l][31-p] : right_i.lane_data[l][63-p];
			end
			#HALF_NS;
			bit_clock_o = 1'b1;
			n = (n + 1) % 64;
		end
	end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
`include "sap_params.svh"
module testbench
	import sap_pkg::*;
;
	localparam sap_frame_t MAIN_L = 128'h13579BDF_80000001_FFFF0000_02468ACE;
	localparam sap_frame_t CONV_L = {4{32'hC0DE5A0F}};
	localparam sap_frame_t CONV_R = {4{32'h3C96E1F0}};
	localparam sap_frame_t TX_F   = 128'hA5A50003_5A5A0002_F0F00001_0F0F0000;

	logic        clock, reset, master, loop, far_run, rx_ready, tx_valid, last_f;
	logic        bo, bo_oe, fo, fo_oe, bo_q, fo_q, rx_valid, ovr, tx_ready;
	logic        main_b, main_f, conv_b, conv_f;
	logic [3:0]  route, sout, sin, main_d, conv_d, tx_hits, sout_q;
	logic [7:0]  rx_hits;
	logic [31:0] tx_sr [4];
	sap_frame_t  tx_frame, exp_l, exp_r;
	sap_word_t   rx_word;
	int          fails, check_count, cycles, rx_taken;
	wire logic   bclk_w = bo_oe ? main_b : bo;
	wire logic   fclk_w = fo_oe ? main_f : fo;

	assign sin = loop ? sout : (main_d & ~route) | (conv_d & route);

	sap_port dut_u (.clock_i(clock), .reset_i(reset), .master_mode_i(master),
		.route_to_converter_i(route), .main_bit_clock_i(bclk_w), .main_bit_clock_o(bo),
		.main_bit_clock_oe_n_o(bo_oe), .main_frame_clock_i(fclk_w),
		.main_frame_clock_o(fo), .main_frame_clock_oe_n_o(fo_oe),
		.converter_bit_clock_i(conv_b), .converter_frame_clock_i(conv_f),
		.serial_audio_in_i(sin), .serial_audio_out_o(sout), .rx_valid_o(rx_valid),
		.rx_ready_i(rx_ready), .rx_word_o(rx_word), .rx_overrun_o(ovr),
		.tx_valid_i(tx_valid), .tx_frame_i(tx_frame), .tx_ready_o(tx_ready));

	sap_far_end #(.HALF_NS(80)) far_main_u (.run_i(far_run), .left_i(MAIN_L),
		.right_i(~MAIN_L), .bit_clock_o(main_b), .frame_clock_o(main_f), .data_o(main_d));
	// slower converter source so the two pairs drift apart in phase
	sap_far_end #(.HALF_NS(100)) far_conv_u (.run_i(far_run), .left_i(CONV_L),
		.right_i(CONV_R), .bit_clock_o(conv_b), .frame_clock_o(conv_f), .data_o(conv_d));

	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		check_count++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// monitors
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			finish_test();
		end
	end

	// output change seen one clock later, while the wire bit clock must still be low
	always @(posedge clock) begin
		bo_q <= bo;
		fo_q <= fo;
		sout_q <= sout;
		if (fo_oe === 1'b0 && fo !== fo_q) check({bo_q, bo}, 2'b10);
		if (reset === 1'b0 && sout !== sout_q) check(bclk_w, 1'b0);
	end

	always @(posedge clock) if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
		rx_taken <= rx_taken + 1;
		if (rx_word.data === (rx_word.right ? exp_r.lane_data[rx_word.lane]
				: exp_l.lane_data[rx_word.lane]))
			rx_hits[{rx_word.lane, rx_word.right}] <= 1'b1;
	end

	// receiver view of the wire: sample at rise, slot ends at frame change
	always @(posedge bclk_w) begin
		for (int l = 0; l < 4; l++) begin
			tx_sr[l] <= {tx_sr[l][30:0], sout[l]};
			if (fclk_w !== last_f && {tx_sr[l][30:0], sout[l]} === TX_F.lane_data[l])
				tx_hits[l] <= 1'b1;
		end
		last_f <= fclk_w;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic run_frames(input int n);
		far_run <= 1'b1;
		repeat (n * 512) @(posedge clock);
		far_run <= 1'b0;
		repeat (800) @(posedge clock);
	endtask

	task automatic send(input sap_frame_t f);
		tx_frame <= f;
		tx_valid <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 2000 && tx_ready !== 1'b1; i++) @(posedge clock);
		tx_valid <= 1'b0;
	endtask

	task automatic rx_test();
		rx_hits <= 8'h00;
		exp_l <= MAIN_L;
		exp_r <= ~MAIN_L;
		run_frames(3);
		check(rx_hits, 8'hFF);
		check(ovr, 1'b0);
		$display("test rx done");
	endtask

	task automatic conv_test();
		rx_hits <= 8'h00;
		route <= 4'h4;
		exp_l <= {MAIN_L[127:96], CONV_L[95:64], MAIN_L[63:0]};
		exp_r <= {~MAIN_L[127:96], CONV_R[95:64], ~MAIN_L[63:0]};
		run_frames(3);
		check(rx_hits, 8'hFF);
		$display("test converter done");
	endtask

	task automatic tx_test();
		tx_hits <= 4'h0;
		route <= 4'h0;
		send(TX_F);
		run_frames(2);
		check(tx_hits, 4'hF);
		$display("test tx done");
	endtask

	task automatic master_test();
		master <= 1'b1;
		loop <= 1'b1;
		rx_hits <= 8'h00;
		tx_hits <= 4'h0;
		exp_l <= TX_F;
		exp_r <= TX_F;
		repeat (3) @(posedge clock);
		check({bo_oe, fo_oe}, 2'b00);
		send(TX_F);
		repeat (1600) @(posedge clock);
		check(tx_hits, 4'hF);
		check({|rx_hits[7:6], |rx_hits[5:4], |rx_hits[3:2], |rx_hits[1:0]}, 4'hF);
		master <= 1'b0;
		loop <= 1'b0;
		repeat (3) @(posedge clock);
		check({bo_oe, fo_oe}, 2'b11);
		$display("test master done");
	endtask

	// buffer fills while the consumer stalls, then drains
	task automatic overrun_test();
		rx_ready <= 1'b0;
		run_frames(3);
		check({ovr, rx_valid}, 2'b11);
		rx_taken <= 0;
		rx_ready <= 1'b1;
		repeat (100) @(posedge clock);
		check(rx_taken >= 17 && rx_taken <= 21, 1'b1);
		$display("test overrun done");
	endtask

	initial begin
		reset = 1'b1;
		master = 1'b0;
		loop = 1'b0;
		far_run = 1'b0;
		route = 4'h0;
		rx_ready = 1'b1;
		tx_valid = 1'b0;
		tx_frame = '0;
		exp_l = '0;
		exp_r = '0;
		rx_hits = 8'h00;
		tx_hits = 4'h0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check({bo_oe, fo_oe, bo, fo, sout, rx_valid, ovr, tx_ready}, 11'h601);
		rx_test();
		conv_test();
		tx_test();
		master_test();
		overrun_test();
		finish_test();
	end
endmodule

// >>> verilog/sap_fifo.sv
`timescale 1ns/100ps
module sap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side, read data registered
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic             push;
	logic             pop;

	assign in_ready_o = (count != CW'(DEPTH));
	assign push       = in_valid_i && in_ready_o;
	assign pop        = (count != '0) && (!out_valid_o || out_ready_i);

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count  <= count + CW'(push) - CW'(pop);
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem[rd_ptr];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule

// >>> verilog/sap_params.svh
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH
// ----------------------------------------
// port geometry
// ----------------------------------------
`define SAP_LANES        4
`define SAP_SLOT_BITS    32
`define SAP_MIN_FRAME    64
`define SAP_FIFO_DEPTH   16
// ----------------------------------------
// timing
// ----------------------------------------
`define SAP_CLK_MHZ      50
`define SAP_BCLK_NS      160
`define SAP_HALF_CYC     ((`SAP_BCLK_NS * `SAP_CLK_MHZ) / 2000)
`define SAP_SYNC_STAGES  2
`endif

// >>> verilog/sap_pkg.sv
`include "sap_params.svh"
package sap_pkg;
	typedef enum logic {
		SAP_SLAVE  = 1'b0,
		SAP_MASTER = 1'b1
	} sap_mode_t;

	// one received slot: lane, side and data
	typedef struct packed {
		logic [1:0]                 lane;
		logic                       right;
		logic [`SAP_SLOT_BITS-1:0]  data;
	} sap_word_t;

	// one slot for each of the output lanes
	typedef struct packed {
		logic [`SAP_LANES-1:0][`SAP_SLOT_BITS-1:0] lane_data;
	} sap_frame_t;
endpackage

// >>> verilog/sap_port.sv
// Summary of operation
// - normal inputs use main bit/frame clocks
// - converter-routed inputs use converter clock pair
// - slave frame clock sampled on rising edge
// - input data captured on rising edge
// - output data changes after falling edge
// - master frame clock changes on falling edge
// - clocks in slave, out in master; slave after reset
// - main clock pair frames outputs and non-routed inputs
`timescale 1ns/100ps
`include "sap_params.svh"
module sap_port
	import sap_pkg::*;
#(
	parameter int SLOT_BITS  = `SAP_SLOT_BITS,
	parameter int FIFO_DEPTH = `SAP_FIFO_DEPTH,
	parameter int HALF_CYC   = `SAP_HALF_CYC
) (
	// clock and reset
	input  wire logic                  clock_i,
	input  wire logic                  reset_i,
	// configuration
	input  wire logic                  master_mode_i,
	input  wire logic [`SAP_LANES-1:0] route_to_converter_i,
	// main clock pair, two-way pins
	input  wire logic                  main_bit_clock_i,
	output logic                       main_bit_clock_o,
	output logic                       main_bit_clock_oe_n_o,
	input  wire logic                  main_frame_clock_i,
	output logic                       main_frame_clock_o,
	output logic                       main_frame_clock_oe_n_o,
	// converter clock pair, inputs only
	input  wire logic                  converter_bit_clock_i,
	input  wire logic                  converter_frame_clock_i,
	// serial data
	input  wire logic [`SAP_LANES-1:0] serial_audio_in_i,
	output logic      [`SAP_LANES-1:0] serial_audio_out_o,
	// received words
	output logic                       rx_valid_o,
	input  wire logic                  rx_ready_i,
	output sap_word_t                  rx_word_o,
	output logic                       rx_overrun_o,
	// words to send
	input  wire logic                  tx_valid_i,
	input  wire sap_frame_t            tx_frame_i,
	output logic                       tx_ready_o
);
	localparam int NL = `SAP_LANES;
	localparam int BW = $clog2(SLOT_BITS);
	localparam int HW = $clog2(HALF_CYC + 1);
	localparam int SW = $clog2(`SAP_SYNC_STAGES + 2);
	logic [SW-1:0] settle;

	if (SLOT_BITS != `SAP_SLOT_BITS || 2 * SLOT_BITS < `SAP_MIN_FRAME || HALF_CYC < 2)
	begin : g_chk
		$error("unsupported slot width or bit clock divider");
	end

	function automatic logic rise(input logic cur, input logic prev);
		return cur && !prev;
	endfunction

	// ----------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------
	logic [7:0] s_pins;
	logic       s_mb;
	logic       s_mlr;
	logic       s_cb;
	logic       s_clr;
	logic       p_mb;
	logic       p_cb;
	logic       m_rise;
	logic       m_fall;
	logic       c_rise;
	logic       armed;

	// the pin is read back even in master mode, so data and clock share one delay
	sap_sync #(.WIDTH(8)) u_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.async_i ({converter_frame_clock_i, converter_bit_clock_i, main_frame_clock_i,
			main_bit_clock_i, serial_audio_in_i}),
		.sync_o  (s_pins)
	);
	assign {s_clr, s_cb, s_mlr, s_mb} = s_pins[7:4];

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			p_mb   <= 1'b0;
			p_cb   <= 1'b0;
			settle <= '0;
		end else begin
			p_mb   <= s_mb;
			p_cb   <= s_cb;
			settle <= armed ? settle : settle + SW'(1);
		end
	end
	// edges held off until the synchronisers show real pin levels, else an idle-high pin fakes a rise
	assign armed  = (settle == SW'(`SAP_SYNC_STAGES + 1));
	assign m_rise = armed && rise(s_mb, p_mb);
	assign m_fall = armed && rise(p_mb, s_mb);
	assign c_rise = armed && rise(s_cb, p_cb);

	// ----------------------------------------
	// mode and master clock generation
	// ----------------------------------------
	sap_mode_t      mode;
	logic [HW-1:0]  div_cnt;
	logic [BW-1:0]  gen_bits;
	logic           gen_fall;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mode                    <= SAP_SLAVE;
			main_bit_clock_oe_n_o   <= 1'b1;
			main_frame_clock_oe_n_o <= 1'b1;
		end else begin
			mode                    <= sap_mode_t'(master_mode_i);
			main_bit_clock_oe_n_o   <= !master_mode_i;
			main_frame_clock_oe_n_o <= !master_mode_i;
		end
	end

	assign gen_fall = (mode == SAP_MASTER) && (div_cnt == HW'(HALF_CYC - 1))
		&& main_bit_clock_o;

	always_ff @(posedge clock_i) begin
		if (reset_i || mode == SAP_SLAVE) begin
			div_cnt          <= '0;
			main_bit_clock_o <= 1'b0;
		end else if (div_cnt == HW'(HALF_CYC - 1)) begin
			div_cnt          <= '0;
			main_bit_clock_o <= !main_bit_clock_o;
		end else begin
			div_cnt          <= div_cnt + HW'(1);
		end
	end

	// one slot per frame half keeps the frame at 64 bit periods
	always_ff @(posedge clock_i) begin
		if (reset_i || mode == SAP_SLAVE) begin
			gen_bits           <= '0;
			main_frame_clock_o <= 1'b0;
		end else if (gen_fall) begin
			gen_bits <= gen_bits + BW'(1);
			if (gen_bits == BW'(SLOT_BITS - 1)) begin
				main_frame_clock_o <= !main_frame_clock_o;
			end
		end
	end

	// ----------------------------------------
	// receive lanes
	// ----------------------------------------
	logic [NL-1:0]                lane_rise;
	logic [NL-1:0]                lane_lr;
	logic [NL-1:0]                lr_prev;
	logic [NL-1:0][SLOT_BITS-1:0] rx_shift;
	logic [NL-1:0]                done;
	logic [NL-1:0]                pend;
	logic [NL-1:0]                grant;
	sap_word_t                    pend_word [NL];
	sap_word_t                    push_word;
	logic                         push_valid;
	logic                         fifo_ready;

	for (genvar k = 0; k < NL; k++) begin : g_rx
		assign lane_rise[k] = route_to_converter_i[k] ? c_rise : m_rise;
		assign lane_lr[k]   = route_to_converter_i[k] ? s_clr : s_mlr;
		// a frame edge seen on this rise closes the slot with its last bit
		assign done[k]      = lane_rise[k] && (lane_lr[k] != lr_prev[k]);

		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				lr_prev[k]  <= 1'b0;
				rx_shift[k] <= '0;
			end else if (lane_rise[k]) begin
				lr_prev[k]  <= lane_lr[k];
				rx_shift[k] <= {rx_shift[k][SLOT_BITS-2:0], s_pins[k]};
			end
		end

		// new slot beats the grant clearing it
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				pend[k]      <= 1'b0;
				pend_word[k] <= '0;
			end else if (done[k]) begin
				pend[k]      <= 1'b1;
				pend_word[k] <= '{lane: 2'(k), right: lr_prev[k],
					data: {rx_shift[k][SLOT_BITS-2:0], s_pins[k]}};
			end else if (grant[k]) begin
				pend[k]      <= 1'b0;
			end
		end
	end

	// fixed priority is enough: all lanes drain in four cycles of an eight-cycle bit
	always_comb begin
		grant      = '0;
		push_valid = 1'b0;
		push_word  = pend_word[0];
		for (int i = NL - 1; i >= 0; i--) begin
			if (pend[i]) begin
				push_word  = pend_word[i];
				push_valid = 1'b1;
			end
		end
		for (int i = 0; i < NL; i++) begin
			if (pend[i] && fifo_ready && grant == '0) begin
				grant[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rx_overrun_o <= 1'b0;
		end else if (|(done & pend & ~grant)) begin
			rx_overrun_o <= 1'b1;
		end
	end

	sap_fifo #(.WIDTH($bits(sap_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (fifo_ready),
		.in_data_i   (push_word),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i),
		.out_data_o  (rx_word_o)
	);

	// ----------------------------------------
	// transmit lanes, always on the main pair
	// ----------------------------------------
	logic                         tx_fall;
	logic                         tx_lr_seen;
	logic                         tx_new_slot;
	logic                         hold_full;
	logic [NL-1:0][SLOT_BITS-1:0] hold;
	logic [NL-1:0][SLOT_BITS-1:0] tx_shift;
	logic                         tx_take;

	// master uses its own falling edge, which keeps the output delay short
	assign tx_fall = (mode == SAP_MASTER) ? gen_fall : m_fall;
	assign tx_take = tx_valid_i && tx_ready_o;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			tx_lr_seen  <= 1'b0;
			tx_new_slot <= 1'b0;
		end else if (m_rise && s_mlr != tx_lr_seen) begin
			tx_lr_seen  <= s_mlr;
			tx_new_slot <= 1'b1;
		end else if (tx_fall) begin
			tx_new_slot <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			hold_full  <= 1'b0;
			tx_ready_o <= 1'b1;
			hold       <= '0;
		end else if (tx_take) begin
			hold_full  <= 1'b1;
			tx_ready_o <= 1'b0;
			hold       <= tx_frame_i.lane_data;
		end else if (tx_fall && tx_new_slot) begin
			hold_full  <= 1'b0;
			tx_ready_o <= 1'b1;
		end
	end

	for (genvar k = 0; k < NL; k++) begin : g_tx
		// an empty holding stage sends a silent slot
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				tx_shift[k]           <= '0;
				serial_audio_out_o[k] <= 1'b0;
			end else if (tx_fall && tx_new_slot) begin
				tx_shift[k]           <= hold_full ? hold[k] << 1 : '0;
				serial_audio_out_o[k] <= hold_full && hold[k][SLOT_BITS-1];
			end else if (tx_fall) begin
				tx_shift[k]           <= tx_shift[k] << 1;
				serial_audio_out_o[k] <= tx_shift[k][SLOT_BITS-1];
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	slave_pins_idle_a: assert property (
		!master_mode_i |=> mode == SAP_SLAVE && main_bit_clock_oe_n_o && main_frame_clock_oe_n_o)
		else $error("pins driven in slave mode");
	reset_to_slave_a: assert property (disable iff (1'b0)
		reset_i |=> mode == SAP_SLAVE && main_bit_clock_oe_n_o)
		else $error("port not slave after reset");
	out_after_fall_a: assert property (
		$changed(serial_audio_out_o) |-> $past(tx_fall))
		else $error("output data changed without falling edge");
	frame_on_fall_a: assert property (
		$changed(main_frame_clock_o) && $past(mode) == SAP_MASTER |-> $past(gen_fall))
		else $error("frame clock moved off falling edge");
	bit_half_period_a: assert property (
		mode == SAP_MASTER && $changed(main_bit_clock_o) && $past(mode) == SAP_MASTER
		|=> ($stable(main_bit_clock_o) || $past(mode) == SAP_SLAVE) [*3])
		else $error("bit clock half period too short");
	tx_main_clock_a: assert property (
		tx_fall && mode == SAP_SLAVE |-> $fell(s_mb))
		else $error("transmit not on main bit clock");
	push_when_room_a: assert property (
		push_valid && fifo_ready |-> $onehot(grant))
		else $error("pending slot not granted to fifo");
	for (genvar k = 0; k < NL; k++) begin : g_chk_rx
		rx_on_rise_a: assert property (
			$changed(rx_shift[k]) |-> $past(lane_rise[k]))
			else $error("input bit taken off rising edge");
		lane_clock_a: assert property (
			lane_rise[k] |-> (route_to_converter_i[k] ? $rose(s_cb) : $rose(s_mb)))
			else $error("lane timed by wrong clock pair");
		frame_on_rise_a: assert property (
			$changed(lr_prev[k]) |-> $past(lane_rise[k]) ##0 pend[k])
			else $error("frame edge not taken on rising edge");
	end

	cover_rx_word_c: cover property (rx_valid_o && rx_ready_i);
	cover_master_c:  cover property (mode == SAP_MASTER && $changed(main_frame_clock_o));
	cover_tx_load_c: cover property (tx_fall && tx_new_slot && hold_full);
	cover_conv_c:    cover property (route_to_converter_i[0] && done[0]);
endmodule

// >>> verilog/sap_sync.sv
`timescale 1ns/100ps
module sap_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	// levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule
